/* File: include/nebcp_pkg.sv */
package nebcp_pkg;

  // Clock rate and pin timing; least times round up to whole cycles.
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned T_SETUP_NS = 20;
  localparam int unsigned T_PULSE_NS = 50;
  localparam int unsigned T_HOLD_NS = 30;
  localparam int unsigned T_ACC_NS = 120;
  localparam logic [7:0] T_SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] T_PULSE_CYC = 8'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] T_HOLD_CYC = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] T_ACC_CYC = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
  // Two extra cycles cover the pin synchroniser.
  localparam logic [7:0] T_RD_CYC = 8'(T_ACC_CYC + 8'h02);

  // Command codes written on the low data byte.
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_BC_SETUP1 = 8'heb;
  localparam logic [7:0] CMD_BC_SETUP2 = 8'h76;
  localparam logic [7:0] CMD_BC_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h30;

  // Status word bits seen while polling.
  localparam int unsigned DQ_TOGGLE_BIT = 6;
  localparam int unsigned DQ_FAIL_BIT = 5;

  // Register offsets of the software port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_POLL = 8'h0c;
  localparam logic [7:0] REG_PIN = 8'h10;

  // Status register bit positions.
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_SUSP = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned ST_RECHECK = 3;
  localparam int unsigned ST_WP = 4;
  localparam int unsigned ST_ACCEL = 5;
  localparam int unsigned ST_REFUSED = 6;

  // Reset value of the write-protect level (pin high, not protecting).
  localparam logic WP_RST = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE, OP_RESET, OP_SUSPEND, OP_RESUME, OP_BLANK, OP_ACCEL
  } nebcp_op_t;

  typedef enum {
    S_IDLE, S_WSET, S_WPUL, S_WHLD, S_RSET, S_RSMP, S_RGAP
  } nebcp_state_t;

endpackage : nebcp_pkg

/* File: verilog/nebcp_host.sv */
`timescale 1ns/1ps
`default_nettype none

module nebcp_host #(
  parameter int ADDR_W = 26,
  parameter int DQ_W = 16
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [ADDR_W-1:0] FA,
  output logic [DQ_W-1:0] FDQ_O,
  output logic FDQ_OE,
  input wire logic [DQ_W-1:0] FDQ_I,
  output logic FCE_N,
  output logic FWE_N,
  output logic FOE_N,
  output logic FRST_N,
  output logic FWP,
  output logic FACCEL
);
  import nebcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command tables.

  // Command byte for each write of an operation.
  function automatic logic [7:0] step_cmd(nebcp_op_t o, logic [1:0] s);
    logic [7:0] c;
    c = CMD_RESET;
    unique case (o)
      OP_SUSPEND: c = CMD_SUSPEND;
      OP_RESUME: c = (s == 2'h0) ? CMD_RESET : CMD_RESUME;
      OP_BLANK: c = (s == 2'h0) ? CMD_BC_SETUP1 :
                    (s == 2'h1) ? CMD_BC_SETUP2 : CMD_BC_CONFIRM;
      OP_ACCEL: c = (s == 2'h0) ? CMD_ERASE_SETUP : CMD_CHIP_CONFIRM;
      OP_RESET, OP_NONE: c = CMD_RESET;
    endcase
    return c;
  endfunction : step_cmd

  // Index of the last write in an operation (one less than its number of writes).
  function automatic logic [1:0] step_last(nebcp_op_t o);
    logic [1:0] n;
    n = 2'h0;
    unique case (o)
      OP_RESUME, OP_ACCEL: n = 2'h1;
      OP_BLANK: n = 2'h2;
      OP_RESET, OP_SUSPEND, OP_NONE: n = 2'h0;
    endcase
    return n;
  endfunction : step_last

  function automatic logic op_polls(nebcp_op_t o);
    return (o == OP_SUSPEND) || (o == OP_BLANK) || (o == OP_ACCEL);
  endfunction : op_polls

  ////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser; only the second stage is read by logic.

  logic [DQ_W-1:0] dq_s1;
  logic [DQ_W-1:0] dq_s2;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= FDQ_I;
      dq_s2 <= dq_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and registers.

  nebcp_state_t state, next_state;
  nebcp_op_t op, next_op;
  logic [7:0] cnt, next_cnt;
  logic [1:0] step, next_step;
  logic [ADDR_W-1:0] blk_addr, next_blk_addr;
  logic [DQ_W-1:0] prev_word, next_prev_word;
  logic have_prev, next_have_prev;
  logic fixing, next_fixing;
  logic pdone, next_pdone;
  logic pfail, next_pfail;
  logic suspended, next_suspended;
  logic fail, next_fail;
  logic recheck, next_recheck;
  logic refused, next_refused;
  logic [31:0] next_rdata;
  logic [ADDR_W-1:0] next_fa;
  logic [DQ_W-1:0] next_fdq_o;
  logic next_fdq_oe, next_fce_n, next_fwe_n, next_foe_n, next_fwp;
  logic next_faccel;

  // Software starts an operation by writing its code while idle.
  logic start;
  nebcp_op_t req_op;
  assign req_op = nebcp_op_t'(REG_WDATA[2:0]);
  assign start = REG_WR && (REG_ADDR == REG_CTRL) && (state == S_IDLE);

  // Next values for the pin sequencer and the register file together.
  always_comb begin
    logic finish;
    logic go_write;
    logic [1:0] wstep;
    finish = 1'b0;
    go_write = 1'b0;
    wstep = 2'h0;
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_step = step;
    next_blk_addr = blk_addr;
    next_prev_word = prev_word;
    next_have_prev = have_prev;
    next_fixing = fixing;
    next_pdone = pdone;
    next_pfail = pfail;
    next_suspended = suspended;
    next_fail = fail;
    next_recheck = recheck;
    next_refused = refused;
    next_fa = FA;
    next_fdq_o = FDQ_O;
    next_fdq_oe = FDQ_OE;
    next_fce_n = FCE_N;
    next_fwe_n = FWE_N;
    next_foe_n = FOE_N;
    next_fwp = FWP;
    next_faccel = FACCEL;
    next_rdata = '0;
    // The port shares its name with the offset, so the offset is scoped.
    if (REG_WR && REG_ADDR == nebcp_pkg::REG_ADDR) begin
      next_blk_addr = REG_WDATA[ADDR_W-1:0];
    end
    if (REG_WR && REG_ADDR == REG_PIN) begin
      next_fwp = REG_WDATA[0];
    end
    // Busy means a chip erase may be running, so no suspend is sent then.
    if (REG_WR && REG_ADDR == REG_CTRL && state != S_IDLE) begin
      next_refused = 1'b1;
    end
    unique case (state)
      S_IDLE: begin
        if (start && req_op != OP_NONE) begin
          // Codes above the last operation are refused, never decoded.
          if ((req_op == OP_RESUME && !suspended) || req_op > OP_ACCEL) begin
            next_refused = 1'b1;
          end else begin
            next_op = req_op;
            next_refused = 1'b0;
            next_fail = 1'b0;
            next_fixing = 1'b0;
            next_have_prev = 1'b0;
            if (req_op == OP_BLANK) begin
              next_recheck = 1'b0;
            end
            next_fa = blk_addr;
            next_faccel = (req_op == OP_ACCEL);
            next_fdq_o = {{(DQ_W-8){1'b0}}, step_cmd(req_op, 2'h0)};
            next_step = 2'h0;
            next_fdq_oe = 1'b1;
            next_fce_n = 1'b0;
            next_cnt = T_SETUP_CYC;
            next_state = S_WSET;
          end
        end
      end
      S_WSET: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_fwe_n = 1'b0;
          next_cnt = T_PULSE_CYC;
          next_state = S_WPUL;
        end
      end
      S_WPUL: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_fwe_n = 1'b1;
          next_cnt = T_HOLD_CYC;
          next_state = S_WHLD;
        end
      end
      S_WHLD: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_fce_n = 1'b1;
          next_fdq_oe = 1'b0;
          if (fixing) begin
            finish = 1'b1;
          end else if (step != step_last(op)) begin
            go_write = 1'b1;
            wstep = step + 2'h1;
          end else if (op_polls(op)) begin
            // Status reads return the polling word while busy.
            next_fce_n = 1'b0;
            next_foe_n = 1'b0;
            next_cnt = T_RD_CYC;
            next_state = S_RSET;
          end else begin
            finish = 1'b1;
          end
        end
      end
      S_RSET: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_state = S_RSMP;
        end
      end
      S_RSMP: begin
        // Two equal toggle bits in a row mean the controller has stopped.
        next_pdone = have_prev &&
          (dq_s2[DQ_TOGGLE_BIT] == prev_word[DQ_TOGGLE_BIT]);
        // Fail needs the flag in both reads, so array data met right after
        // the last busy word cannot pass for an error.
        next_pfail = have_prev && dq_s2[DQ_FAIL_BIT] &&
          prev_word[DQ_FAIL_BIT] &&
          (dq_s2[DQ_TOGGLE_BIT] != prev_word[DQ_TOGGLE_BIT]);
        next_prev_word = dq_s2;
        next_have_prev = 1'b1;
        next_foe_n = 1'b1;
        next_fce_n = 1'b1;
        next_cnt = T_HOLD_CYC;
        next_state = S_RGAP;
      end
      S_RGAP: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          if (pdone) begin
            finish = 1'b1;
          end else if (pfail) begin
            // Error status stays on the pins until read/reset is written.
            next_fail = 1'b1;
            next_fixing = 1'b1;
            go_write = 1'b1;
            wstep = 2'h0;
          end else begin
            next_fce_n = 1'b0;
            next_foe_n = 1'b0;
            next_cnt = T_RD_CYC;
            next_state = S_RSET;
          end
        end
      end
    endcase
    if (go_write) begin
      next_step = wstep;
      next_fdq_o = {{(DQ_W-8){1'b0}},
        (next_fixing ? CMD_RESET : step_cmd(op, wstep))};
      next_fdq_oe = 1'b1;
      next_fce_n = 1'b0;
      next_cnt = T_SETUP_CYC;
      next_state = S_WSET;
    end
    if (finish) begin
      next_state = S_IDLE;
      next_faccel = 1'b0;
      if (op == OP_SUSPEND) begin
        next_suspended = 1'b1;
      end
      if (op == OP_RESUME) begin
        next_suspended = 1'b0;
      end
      if (op == OP_ACCEL && fail) begin
        next_recheck = 1'b1;
      end
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_CTRL: next_rdata = {29'h0, op};
        nebcp_pkg::REG_ADDR: next_rdata = 32'(blk_addr);
        REG_STATUS: begin
          next_rdata[ST_BUSY] = (state != S_IDLE);
          next_rdata[ST_SUSP] = suspended;
          next_rdata[ST_FAIL] = fail;
          next_rdata[ST_RECHECK] = recheck;
          next_rdata[ST_WP] = FWP;
          next_rdata[ST_ACCEL] = FACCEL;
          next_rdata[ST_REFUSED] = refused;
        end
        REG_POLL: next_rdata = 32'(prev_word);
        REG_PIN: next_rdata = {31'h0, FWP};
        default: next_rdata = '0;
      endcase
    end
  end

  // Registers only; all outputs come from here.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      op <= OP_NONE;
      cnt <= 8'h00;
      step <= 2'h0;
      blk_addr <= '0;
      prev_word <= '0;
      have_prev <= 1'b0;
      fixing <= 1'b0;
      pdone <= 1'b0;
      pfail <= 1'b0;
      suspended <= 1'b0;
      fail <= 1'b0;
      recheck <= 1'b0;
      refused <= 1'b0;
      REG_RDATA <= 32'h0;
      FA <= '0;
      FDQ_O <= '0;
      FDQ_OE <= 1'b0;
      FCE_N <= 1'b1;
      FWE_N <= 1'b1;
      FOE_N <= 1'b1;
      FRST_N <= 1'b0;
      FWP <= WP_RST;
      FACCEL <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      step <= next_step;
      blk_addr <= next_blk_addr;
      prev_word <= next_prev_word;
      have_prev <= next_have_prev;
      fixing <= next_fixing;
      pdone <= next_pdone;
      pfail <= next_pfail;
      suspended <= next_suspended;
      fail <= next_fail;
      recheck <= next_recheck;
      refused <= next_refused;
      REG_RDATA <= next_rdata;
      FA <= next_fa;
      FDQ_O <= next_fdq_o;
      FDQ_OE <= next_fdq_oe;
      FCE_N <= next_fce_n;
      FWE_N <= next_fwe_n;
      FOE_N <= next_foe_n;
      FRST_N <= 1'b1; // Flash reset is released one edge after ours.
      FWP <= next_fwp;
      FACCEL <= next_faccel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  suspend_code_a: assert property (
    (state == S_WPUL && op == OP_SUSPEND && !fixing) |->
      (FDQ_O[7:0] == 8'hb0 && FDQ_OE && !FWE_N && !FCE_N))
    else $error("Suspend write carries wrong code");
  resume_exit_a: assert property (
    (state == S_WPUL && op == OP_RESUME && step == 2'h0) |->
      FDQ_O[7:0] == 8'hf0)
    else $error("Resume not preceded by read/reset");
  blank_confirm_a: assert property (
    (state == S_WPUL && op == OP_BLANK && step == 2'h2 && !fixing) |->
      FDQ_O[7:0] == 8'h29 && $past(FDQ_O[7:0], 6) == 8'h76)
    else $error("Blank check confirm out of order");
  accel_only_a: assert property (
    FACCEL |-> (op == OP_ACCEL && state != S_IDLE))
    else $error("Acceleration voltage outside chip erase");
  accel_drop_a: assert property (
    (state != S_IDLE ##1 state == S_IDLE) |-> !FACCEL)
    else $error("Acceleration voltage left on after operation");
  recheck_set_a: assert property (
    ($past(state) != S_IDLE && state == S_IDLE && op == OP_ACCEL && fail)
      |-> recheck)
    else $error("Failed chip erase not flagged for recheck");
  fail_reset_a: assert property (
    $rose(fixing) |-> ##2 (!FWE_N && FDQ_O[7:0] == 8'hf0))
    else $error("Read/reset not sent after failure");
  we_width_a: assert property (
    $fell(FWE_N) |-> (!FWE_N)[*3] ##1 FWE_N)
    else $error("Write pulse width wrong");

  suspend_done_c: cover property (
    $past(state) != S_IDLE && state == S_IDLE && op == OP_SUSPEND);
  resume_done_c: cover property ($fell(suspended));
  blank_fail_c: cover property ($rose(fail) && op == OP_BLANK);
  accel_recheck_c: cover property ($rose(recheck));

endmodule : nebcp_host

`default_nettype wire

/* File: verif/nebcp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural flash; busy phases last a few polling reads, not real time.
module nebcp_flash_model (
  input wire logic [25:0] FA,
  input wire logic [15:0] FDQ_O,
  output logic [15:0] FDQ_I,
  input wire logic FCE_N,
  input wire logic FWE_N,
  input wire logic FOE_N,
  input wire logic FRST_N,
  input wire logic FWP,
  input wire logic FACCEL
);
  logic erasing = 0, suspended = 0, chip = 0, err = 0, tog = 0;
  logic dirty = 0, accel_fail = 0, bc_fail = 0;
  logic [7:0] prev = 8'h00, vol_bit = 8'hff;
  logic [25:0] erase_blk = 26'h0, bc_blk = 26'h0;
  logic [15:0] word;
  int busy_left = 0, misuse = 0;

  // Hardware reset drops erase, suspend, error and busy state and sets volatile bits to 1.
  always @(negedge FRST_N) begin
    erasing = 0; suspended = 0; err = 0; busy_left = 0;
    vol_bit = 8'hff;
  end

  // Commands are latched on the rising write strobe.
  always @(posedge FWE_N) if (!FCE_N) begin
    if (FACCEL && (FDQ_O[7:0] == 8'heb || FDQ_O[7:0] == 8'hb0))
      misuse++;
    case (FDQ_O[7:0])
      8'hf0: err = 0;
      8'hb0: if (erasing && !chip && !suspended) begin
        suspended = 1;
        busy_left = 2;
      end
      8'h30: if (prev == 8'h80 && FACCEL) begin
        chip = 1;
        busy_left = 6;
      end else if (suspended) begin
        suspended = 0;
      end
      8'h29: if (prev == 8'h76) begin
        bc_blk = FA;
        bc_fail = dirty;
        busy_left = 4;
      end
      default: ;
    endcase
    prev = FDQ_O[7:0];
  end

  // Each completed read advances the toggle bit while busy or failed.
  always @(posedge FOE_N) if (busy_left > 0 || err) begin
    tog = ~tog;
    if (busy_left > 0) begin
      busy_left--;
      if (busy_left == 0) begin
        err = (chip && accel_fail) || (!chip && bc_fail);
        chip = 0;
      end
    end
  end

  // Status replaces array data while busy, failed or on the held block.
  always_comb begin
    if (busy_left > 0 || err) word = {9'h0, tog, err, 5'h0};
    else if (suspended && FA == erase_blk) word = 16'h0080;
    else word = 16'hffff;
  end

  // A released bus shows the inverse so a stale value never passes.
  assign FDQ_I = (!FCE_N && !FOE_N) ? word : ~word;
endmodule : nebcp_flash_model

`default_nettype wire

/* File: verif/nebcp_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module nebcp_host_tb;
  import nebcp_pkg::*;
  logic CLK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rd;
  logic [25:0] FA;
  logic [15:0] FDQ_O, FDQ_I;
  logic FDQ_OE, FCE_N, FWE_N, FOE_N, FRST_N, FWP, FACCEL;
  int bad_count = 0, tests_run = 0;

  // Free-running 50 MHz clock.
  always #10 CLK = ~CLK;

  nebcp_host uut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FA(FA), .FDQ_O(FDQ_O), .FDQ_OE(FDQ_OE),
    .FDQ_I(FDQ_I), .FCE_N(FCE_N), .FWE_N(FWE_N), .FOE_N(FOE_N),
    .FRST_N(FRST_N), .FWP(FWP), .FACCEL(FACCEL));

  nebcp_flash_model flash (.FA(FA), .FDQ_O(FDQ_O), .FDQ_I(FDQ_I),
    .FCE_N(FCE_N), .FWE_N(FWE_N), .FOE_N(FOE_N), .FRST_N(FRST_N),
    .FWP(FWP), .FACCEL(FACCEL));

  task automatic check32(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check32

  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe.
  task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    d = REG_RDATA;
  endtask : reg_rd

  // Polls the busy bit under a bound; running out counts as a mismatch.
  task automatic wait_idle;
    logic [31:0] s;
    for (int i = 0; i < 2000; i++) begin
      reg_rd(REG_STATUS, s);
      if (s[ST_BUSY] === 1'b0) return;
    end
    check32("busy_timeout", 32'h0, s);
  endtask : wait_idle

  task automatic run_op(logic [31:0] op, logic [31:0] exp_status);
    reg_wr(REG_CTRL, op);
    wait_idle();
    reg_rd(REG_STATUS, rd);
    check32("status", exp_status, rd);
  endtask : run_op

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // A hang is cut well inside the cycle budget.
  initial begin
    #1500000;
    bad_count++;
    stop_test();
  end

  // Main sequence of register-level scenarios.
  initial begin
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    reg_rd(REG_STATUS, rd);
    check32("status_reset", 32'h10, rd);
    reg_rd(REG_PIN, rd);
    check32("pin_reset", 32'h1, rd);
    reg_rd(8'h20, rd);
    check32("unmapped", 32'h0, rd);
    // Read data stand one cycle only and fall back to zero.
    @(negedge CLK);
    check32("rdata_idle", 32'h0, REG_RDATA);
    flash.erasing = 1;
    flash.erase_blk = 26'h5;
    reg_wr(nebcp_pkg::REG_ADDR, 32'h5);
    reg_rd(nebcp_pkg::REG_ADDR, rd);
    check32("blk_addr", 32'h5, rd);
    for (int i = 0; i < 2; i++) begin
      run_op(32'h2, 32'h12);
      reg_rd(REG_POLL, rd);
      check32("poll_susp", 32'h80, rd);
      check32("dev_susp", 32'h1, {31'h0, flash.suspended});
      run_op(32'h3, 32'h10);
      check32("dev_resumed", 32'h0, {31'h0, flash.suspended});
    end
    reg_rd(REG_CTRL, rd);
    check32("last_op", 32'h3, rd);
    flash.erasing = 0;
    run_op(32'h3, 32'h50);
    reg_wr(nebcp_pkg::REG_ADDR, 32'h3);
    run_op(32'h4, 32'h10);
    check32("bc_block", 32'h3, {6'h0, flash.bc_blk});
    flash.dirty = 1;
    run_op(32'h4, 32'h14);
    check32("bc_err_clr", 32'h0, {31'h0, flash.err});
    flash.dirty = 0;
    flash.accel_fail = 1;
    run_op(32'h5, 32'h1c);
    check32("accel_off", 32'h0, {31'h0, FACCEL});
    flash.accel_fail = 0;
    run_op(32'h4, 32'h10);
    check32("accel_misuse", 32'h0, flash.misuse);
    reg_wr(REG_CTRL, 32'h4);
    reg_wr(REG_CTRL, 32'h1);
    wait_idle();
    reg_rd(REG_STATUS, rd);
    check32("busy_refuse", 32'h50, rd);
    reg_wr(REG_PIN, 32'h0);
    reg_rd(REG_STATUS, rd);
    check32("wp_low", 32'h40, rd);
    check32("wp_pin", 32'h0, {31'h0, FWP});
    reg_wr(REG_PIN, 32'h1);
    reg_rd(REG_PIN, rd);
    check32("wp_high", 32'h1, rd);
    stop_test();
  end
endmodule : nebcp_host_tb

`default_nettype wire
